// *** pkg/cbag_pkg.sv ***
// Package with constants and carrier types of the circular buffer address generator.
// Overview of operation
// - Circular addressing may select any working-register pointer by its index except 15, the stack pointer.
// - Non power-of-two buffers check only the boundary facing their direction.
// - Power-of-two buffers check both boundaries and so may run bidirectionally.
// - Four software-loaded 16-bit boundary registers hold X and Y start and end.
// - Y effective addresses are word addresses; their least significant bit reads zero, while Y boundary readback keeps the loaded bit 0.
// - No length register; length is end minus start boundary plus one.
// - Buffers up to 32K words, that is 64 Kbytes, are supported.
// - X circular mode needs select bits 3..0 not fifteen and bit 15 set.
// - Y circular mode needs select bits 7..4 not fifteen and bit 14 set.
package cbag_pkg;

    // ------------------------------------------------------------------
    // Control layout and reset values
    // ------------------------------------------------------------------
    localparam int         CBAG_AW             = 16;
    localparam int         CBAG_XSEL_LSB       = 0;
    localparam int         CBAG_YSEL_LSB       = 4;
    localparam int         CBAG_XEN_BIT        = 15;
    localparam int         CBAG_YEN_BIT        = 14;
    localparam logic [3:0] CBAG_SEL_OFF        = 4'hf;
    localparam logic [3:0] CBAG_FRAME_PTR      = 4'he;
    localparam logic [3:0] CBAG_STACK_PTR      = 4'hf;
    localparam logic [15:0] CBAG_CTRL_RST      = 16'h00ff;
    localparam logic [15:0] CBAG_BND_RST       = 16'h0000;
    localparam logic [16:0] CBAG_MAX_LEN_BYTES = 17'h10000;

    // ------------------------------------------------------------------
    // Boundary register selection on the load port
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CBAG_X_START = 2'b00,
        CBAG_X_END   = 2'b01,
        CBAG_Y_START = 2'b10,
        CBAG_Y_END   = 2'b11
    } cbag_bnd_sel_t;

    typedef struct packed {
        logic        valid;
        logic        inc;
        logic [3:0]  wsel;
        logic [15:0] next_ea;
    } cbag_req_t;

    typedef struct packed {
        logic        valid;
        logic        circular;
        logic        wrapped;
        logic [15:0] ea;
    } cbag_res_t;

endpackage

// *** design/cbag_top.sv ***
// Circular buffer address generator for the X and Y data address units.
`timescale 1ns/1ps

module cbag_top
    import cbag_pkg::*;
(
    input  wire logic          clk_sys,    // System clock, 40 MHz.
    input  wire logic          rst_n,      // Asynchronous reset, active low.
    input  wire logic          ctrl_wr,    // Load pulse for circular_addr_control.
    input  wire logic [15:0]   ctrl_wdata, // New control word.
    input  wire logic          bnd_wr,     // Load pulse for a boundary register.
    input  wire cbag_bnd_sel_t bnd_sel,    // Which boundary register is loaded.
    input  wire logic [15:0]   bnd_wdata,  // New boundary value.
    input  wire cbag_req_t     x_req,      // X pointer update from the core.
    input  wire cbag_req_t     y_req,      // Y pointer update from the core.
    output cbag_res_t          x_res,      // Effective X address, one cycle later.
    output cbag_res_t          y_res,      // Effective Y address, one cycle later.
    output logic [15:0]        circular_addr_control, // Control word readback.
    output logic [15:0]        x_buffer_start,        // X start boundary readback.
    output logic [15:0]        x_buffer_end,          // X end boundary readback.
    output logic [15:0]        y_buffer_start,        // Y start boundary readback.
    output logic [15:0]        y_buffer_end,          // Y end boundary readback.
    output logic               x_circular_active,     // X circular mode enabled.
    output logic               y_circular_active      // Y circular mode enabled.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] xs;
        logic [15:0] xe;
        logic [15:0] ys;
        logic [15:0] ye;
        cbag_res_t   xr;
        cbag_res_t   yr;
    } cbag_state_t;

    cbag_state_t q;
    cbag_state_t next_q;

    // ------------------------------------------------------------------
    // Wrap computation, shared by both address spaces
    // ------------------------------------------------------------------
    // Length is kept 17 bits wide so that a full 64 Kbyte buffer does not alias to zero.
    function automatic logic [16:0] cbag_len(input logic [15:0] s, input logic [15:0] e);
        cbag_len = {1'b0, e} + 17'h00001 - {1'b0, s};
    endfunction

    function automatic logic cbag_pow2(input logic [16:0] len);
        cbag_pow2 = (len != 17'h00000) && ((len & (len - 17'h00001)) == 17'h00000);
    endfunction

    function automatic cbag_res_t cbag_calc(input cbag_req_t r, input logic act,
                                            input logic [15:0] s, input logic [15:0] e);
        logic [16:0] len;
        logic        both;
        len  = cbag_len(s, e);
        both = cbag_pow2(len);
        cbag_calc.valid    = r.valid;
        cbag_calc.circular = act;
        cbag_calc.wrapped  = 1'b0;
        cbag_calc.ea       = r.next_ea;
        if (act) begin
            // A non power-of-two buffer only checks the boundary it runs towards.
            if ((r.inc || both) && (r.next_ea > e)) begin
                cbag_calc.ea      = 16'(r.next_ea - len[15:0]);
                cbag_calc.wrapped = 1'b1;
            end else if ((!r.inc || both) && (r.next_ea < s)) begin
                cbag_calc.ea      = 16'(r.next_ea + len[15:0]);
                cbag_calc.wrapped = 1'b1;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Enables and pointer match
    // ------------------------------------------------------------------
    logic [3:0]  x_sel;
    logic [3:0]  y_sel;
    logic [15:0] ys_w;
    logic [15:0] ye_w;

    assign x_sel             = q.ctrl[CBAG_XSEL_LSB +: 4];
    assign y_sel             = q.ctrl[CBAG_YSEL_LSB +: 4];
    assign x_circular_active = (x_sel != CBAG_SEL_OFF) && q.ctrl[CBAG_XEN_BIT];
    assign y_circular_active = (y_sel != CBAG_SEL_OFF) && q.ctrl[CBAG_YEN_BIT];
    // Y boundaries are taken as whole words, so odd start bits never shift the window.
    assign ys_w              = {q.ys[15:1], 1'b0};
    assign ye_w              = {q.ye[15:1], 1'b1};

    always_comb begin
        next_q = q;
        if (ctrl_wr) begin
            next_q.ctrl = ctrl_wdata;
        end
        if (bnd_wr) begin
            unique case (bnd_sel)
                CBAG_X_START: next_q.xs = bnd_wdata;
                CBAG_X_END:   next_q.xe = bnd_wdata;
                CBAG_Y_START: next_q.ys = bnd_wdata;
                CBAG_Y_END:   next_q.ye = bnd_wdata;
            endcase
        end
        // Any pointer index but 15 may be chosen; the frame pointer is not blocked, the stack pointer (15) is.
        next_q.xr = cbag_calc(x_req, x_circular_active && (x_req.wsel == x_sel), q.xs, q.xe);
        next_q.yr = cbag_calc(y_req, y_circular_active && (y_req.wsel == y_sel), ys_w, ye_w);
        next_q.yr.ea[0] = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q      <= '0;
            q.ctrl <= CBAG_CTRL_RST;
            q.xs   <= CBAG_BND_RST;
            q.xe   <= CBAG_BND_RST;
            q.ys   <= CBAG_BND_RST;
            q.ye   <= CBAG_BND_RST;
        end else begin
            q <= next_q;
        end
    end

    assign x_res                 = q.xr;
    assign y_res                 = q.yr;
    assign circular_addr_control = q.ctrl;
    assign x_buffer_start        = q.xs;
    assign x_buffer_end          = q.xe;
    assign y_buffer_start        = q.ys;
    assign y_buffer_end          = q.ye;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic x_pow2;
    logic x_cfg_still;
    assign x_pow2      = cbag_pow2(cbag_len(q.xs, q.xe));
    assign x_cfg_still = !ctrl_wr && !bnd_wr;

    sequence x_hit_s;
        x_req.valid && x_circular_active && (x_req.wsel == x_sel) && x_cfg_still;
    endsequence

    sequence bnd_xs_load_s;
        bnd_wr && (bnd_sel == CBAG_X_START) ##1 !(bnd_wr && (bnd_sel == CBAG_X_START)) [*2];
    endsequence

    x_sel_off_a: assert property (x_req.valid && (x_sel == CBAG_SEL_OFF)
        |=> x_res.valid && !x_res.circular && (x_res.ea == $past(x_req.next_ea)))
        else $error("X address altered while X circular select is off.");
    y_en_off_a: assert property (y_req.valid && !q.ctrl[CBAG_YEN_BIT] && !ctrl_wr
        |=> !y_res.circular && !y_res.wrapped)
        else $error("Y address wrapped with Y circular enable clear.");
    x_wrap_end_a: assert property (x_hit_s and (x_req.inc && (x_req.next_ea == q.xe + 16'h0001)
        && (q.xe != 16'hffff) && (q.xs <= q.xe))
        |=> x_res.wrapped && (x_res.ea == q.xs))
        else $error("X increment past end did not wrap to start.");
    x_wrap_start_a: assert property (x_hit_s and (!x_req.inc && (x_req.next_ea == q.xs - 16'h0001)
        && (q.xs != 16'h0000) && (q.xs <= q.xe))
        |=> x_res.wrapped && (x_res.ea == q.xe))
        else $error("X decrement below start did not wrap to end.");
    x_one_way_a: assert property (x_hit_s and (x_req.inc && !x_pow2 && (x_req.next_ea < q.xs))
        |=> !x_res.wrapped && (x_res.ea == $past(x_req.next_ea)))
        else $error("X incrementing buffer checked its lower boundary.");
    x_bidir_a: assert property (x_hit_s and (!x_req.inc && x_pow2 && (x_req.next_ea > q.xe))
        |=> x_res.wrapped && (x_res.ea < $past(x_req.next_ea)))
        else $error("X power-of-two buffer missed its upper boundary.");
    y_word_a: assert property (y_req.valid |=> y_res.valid ##0 (y_res.ea[0] == 1'b0))
        else $error("Y effective address has its low bit set.");
    bnd_hold_a: assert property (bnd_xs_load_s |-> (x_buffer_start == $past(bnd_wdata, 2)))
        else $error("X start boundary did not keep the loaded value.");
    x_any_ptr_a: assert property (x_hit_s and (x_req.wsel == CBAG_FRAME_PTR)
        |=> x_res.circular)
        else $error("X circular mode refused a selectable pointer.");
    full_len_a: assert property ((q.xs == 16'h0000) && (q.xe == 16'hffff)
        |-> cbag_len(q.xs, q.xe) == CBAG_MAX_LEN_BYTES)
        else $error("Largest buffer length aliased.");

endmodule

// *** tb/cbag_agu_model.sv ***
// Core Y address unit model that steps a pointer and writes back the effective address.
`timescale 1ns/1ps

module cbag_agu_model
    import cbag_pkg::*;
(
    input  wire logic        clk_sys, // System clock.
    input  wire logic        rst_n,   // Reset, active low.
    input  wire logic        ld,      // Load a pointer value.
    input  wire logic [15:0] ld_ptr,  // Pointer value to load.
    input  wire logic        go,      // Issue one update.
    input  wire logic        inc,     // Step up when high.
    input  wire logic [3:0]  wsel,    // Working register index.
    input  wire cbag_res_t   res,     // Result from the generator.
    output cbag_req_t        req      // Update request.
);
    logic [15:0] ptr;

    // The pointer follows the generated address, as the core's write-back does.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) ptr <= 16'h0000;
        else if (ld) ptr <= ld_ptr;
        else if (res.valid) ptr <= res.ea;
    end

    // One word step in one direction per update; the bench never selects 14 or 15 here.
    assign req = '{go, inc, wsel, inc ? ptr + 16'h0002 : ptr - 16'h0002};
endmodule

// *** tb/tb_circular_buffer_address_gen.sv ***
// Self-checking bench of the circular buffer address generator.
`timescale 1ns/1ps

module tb_circular_buffer_address_gen
    import cbag_pkg::*;
;
    typedef struct packed {
        logic [15:0] c, s, e;
        logic        i;
        logic [3:0]  w;
        logic [15:0] n;
        cbag_res_t   r;
    } cbag_row_t;

    localparam cbag_row_t ROWS[12] = '{
        '{16'h8003, 16'h0100, 16'h010f, 1'b1, 4'h3, 16'h0110, '{1'b1, 1'b1, 1'b1, 16'h0100}},
        '{16'h8003, 16'h0100, 16'h010f, 1'b0, 4'h3, 16'h00fe, '{1'b1, 1'b1, 1'b1, 16'h010e}},
        '{16'h8003, 16'h0100, 16'h010f, 1'b1, 4'h5, 16'h0110, '{1'b1, 1'b0, 1'b0, 16'h0110}},
        '{16'h0003, 16'h0100, 16'h010f, 1'b1, 4'h3, 16'h0110, '{1'b1, 1'b0, 1'b0, 16'h0110}},
        '{16'h800f, 16'h0100, 16'h010f, 1'b1, 4'hf, 16'h0110, '{1'b1, 1'b0, 1'b0, 16'h0110}},
        '{16'h800e, 16'h0100, 16'h010f, 1'b1, 4'he, 16'h0110, '{1'b1, 1'b1, 1'b1, 16'h0100}},
        '{16'h8003, 16'h0100, 16'h0109, 1'b0, 4'h3, 16'h010a, '{1'b1, 1'b1, 1'b0, 16'h010a}},
        '{16'h8003, 16'h0100, 16'h0109, 1'b1, 4'h3, 16'h010a, '{1'b1, 1'b1, 1'b1, 16'h0100}},
        '{16'h8003, 16'h0100, 16'h0109, 1'b1, 4'h3, 16'h00fe, '{1'b1, 1'b1, 1'b0, 16'h00fe}},
        '{16'h8003, 16'h0000, 16'hffff, 1'b1, 4'h3, 16'h8000, '{1'b1, 1'b1, 1'b0, 16'h8000}},
        '{16'h8003, 16'h0100, 16'h0109, 1'b0, 4'h3, 16'h00ff, '{1'b1, 1'b1, 1'b1, 16'h0109}},
        '{16'h8003, 16'h0100, 16'h010f, 1'b0, 4'h3, 16'h0112, '{1'b1, 1'b1, 1'b1, 16'h0102}}
    };

    logic          clk_sys, rst_n, ctrl_wr, bnd_wr, ld, go, inc, x_circular_active, y_circular_active;
    logic [15:0]   ctrl_wdata, bnd_wdata, ld_ptr, circular_addr_control;
    logic [15:0]   x_buffer_start, x_buffer_end, y_buffer_start, y_buffer_end;
    logic [3:0]    wsel;
    cbag_bnd_sel_t bnd_sel;
    cbag_req_t     x_req, y_req;
    cbag_res_t     x_res, y_res;
    int            n_fail, comparisons, cyc;

    cbag_top DUT (.clk_sys, .rst_n, .ctrl_wr, .ctrl_wdata, .bnd_wr, .bnd_sel, .bnd_wdata, .x_req, .y_req,
        .x_res, .y_res, .circular_addr_control, .x_buffer_start, .x_buffer_end, .y_buffer_start,
        .y_buffer_end, .x_circular_active, .y_circular_active);
    cbag_agu_model agu (.clk_sys, .rst_n, .ld, .ld_ptr, .go, .inc, .wsel, .res(y_res), .req(y_req));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Reset is asynchronous, so its values are checked while it is still held.
    task automatic check_rst;
        @(negedge clk_sys);
        chk("ctrl", 32'(circular_addr_control), 32'(CBAG_CTRL_RST));
        chk("bounds", 32'(x_buffer_start | x_buffer_end | y_buffer_start | y_buffer_end), 32'(CBAG_BND_RST));
        chk("active", 32'({x_circular_active, y_circular_active}), 32'h0);
        chk("x_res", 32'(x_res), 32'h0);
        chk("y_res", 32'(y_res), 32'h0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        $display("reset test done");
    endtask

    // The end boundary of the same space is loaded one cycle after its start.
    task automatic setup(input logic [15:0] c, input cbag_bnd_sel_t ss, input logic [15:0] s, e);
        @(posedge clk_sys);
        ctrl_wr    <= 1'b1;
        ctrl_wdata <= c;
        bnd_wr     <= 1'b1;
        bnd_sel    <= ss;
        bnd_wdata  <= s;
        @(posedge clk_sys);
        ctrl_wr   <= 1'b0;
        bnd_sel   <= (ss == CBAG_X_START) ? CBAG_X_END : CBAG_Y_END;
        bnd_wdata <= e;
        @(posedge clk_sys);
        bnd_wr <= 1'b0;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 1000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        {rst_n, ctrl_wr, bnd_wr, ld, go, inc, ctrl_wdata, bnd_wdata, ld_ptr, wsel} = '0;
        bnd_sel = CBAG_X_START;
        x_req = '0;
        repeat (4) @(posedge clk_sys);
        check_rst();
        // -------------------------------------------------------------
        // Ordinary X cases
        // -------------------------------------------------------------
        foreach (ROWS[k]) begin
            setup(ROWS[k].c, CBAG_X_START, ROWS[k].s, ROWS[k].e);
            x_req <= '{1'b1, ROWS[k].i, ROWS[k].w, ROWS[k].n};
            @(posedge clk_sys);
            x_req.valid <= 1'b0;
            @(negedge clk_sys);
            chk("x_res", 32'(x_res), 32'(ROWS[k].r));
            chk("x_bounds", {x_buffer_start, x_buffer_end}, {ROWS[k].s, ROWS[k].e});
            chk("x_active", 32'(x_circular_active), 32'(ROWS[k].c[15] && ROWS[k].c[3:0] != 4'hf));
        end
        $display("x rows test done");
        setup(16'h405f, CBAG_Y_START, 16'h0201, 16'h0207);
        {ld, ld_ptr, inc, wsel} <= {1'b1, 16'h0206, 1'b1, 4'h5};
        @(posedge clk_sys);
        ld <= 1'b0;
        chk("y_active", 32'({x_circular_active, y_circular_active}), 32'h1);
        chk("y_bounds", {y_buffer_start, y_buffer_end}, {16'h0201, 16'h0207});
        chk("ctrl", 32'(circular_addr_control), 32'h405f);
        for (int k = 0; k < 6; k++) begin
            go <= 1'b1;
            @(posedge clk_sys);
            go <= 1'b0;
            inc <= (k != 4);
            @(negedge clk_sys);
            chk("y_res", 32'(y_res), 32'({2'b11, (k % 4 == 0) || (k == 5),
                k == 5 ? 16'h0206 : 16'h0200 + 16'(2 * (k % 4))}));
            @(posedge clk_sys);
        end
        // Same pointer select with the Y enable cleared: the address must pass through untouched.
        setup(16'h005f, CBAG_Y_START, 16'h0201, 16'h0207);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(negedge clk_sys);
        chk("y_off", 32'(y_res), 32'({3'b100, 16'h0208}));
        chk("y_active", 32'({x_circular_active, y_circular_active}), 32'h0);
        $display("y walk test done");
        rst_n <= 1'b0;
        check_rst();
        give_verdict();
    end
endmodule
